// ### sim/rmsi_monitor.sv
// checker for the radio register link and the interrupt pin
// assumes one clock; the bench instantiates it beside the link
`timescale 1ns/1ps
module rmsi_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic irq_out_low
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // address groups whose access may release the pin
  wire logic is_ist = (reg_addr == 7'h03) || (reg_addr == 7'h04);
  wire logic is_ien = (reg_addr == 7'h05) || (reg_addr == 7'h06);
  // one access: request alone, one ack cycle, then both low
  sequence acc_s;
    !reg_ack ##1 reg_ack ##1 (!reg_ack && !reg_req);
  endsequence
  chk_access_shape: assert property ($rose(reg_req) |-> acc_s)
    else $error("link access out of shape");
  chk_ack_single: assert property (reg_ack |=> !reg_ack)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (reg_ack |-> reg_req && $past(reg_req))
    else $error("ack without request");
  chk_req_held: assert property (reg_req && !reg_ack |=>
    $stable(reg_addr) && $stable(reg_we) && $stable(reg_wdata))
    else $error("request changed before ack");
  chk_por_pending: assert property ($rose(hresetn) |-> !irq_out_low)
    else $error("power-on flag not pending");
  chk_status_gap: assert property (reg_ack && !reg_we && reg_addr == 7'h02 |->
    reg_rdata[2] == 1'b0)
    else $error("status bit two not zero");
  chk_unmapped_zero: assert property (reg_ack && !reg_we && reg_addr == 7'h7F |->
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // the pin is only released by a status read or an enable write
  chk_irq_release: assert property ($rose(irq_out_low) |->
    $past(reg_req) && ($past(is_ist) || $past(is_ien)))
    else $error("pin released without cause");
endmodule : rmsi_monitor

// ### sim/test_radio_mode_sequencer_irq.sv
// bench: controller and radio joined by the link, driven over the bus
// assumes short step counts in the radio so sequences finish fast
`timescale 1ns/1ps
module test_radio_mode_sequencer_irq;
  import rmsi_pkg::*;
  logic hclk, hresetn, hsel, hwrite, tx_done, hresp, host_irq;
  wire logic hready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ev_first, ev_second;
  logic [4:0] fifo_flags;
  logic lpr, main_on, wut, lbd, xtal, xbuf, pll, cal, pa, rxfe, mrx;
  int miscompares, num_checks, cyc;
  int t [6];
  // idle modes: opmode value, {main, xtal, pll, wut, lbd}, care mask
  logic [7:0] mode_v [5] = '{8'h00, 8'h40, 8'h20, 8'h01, 8'h02};
  logic [4:0] mode_e [5] = '{5'h00, 5'h02, 5'h11, 5'h18, 5'h1C};
  logic [4:0] mode_m [5] = '{5'h1F, 5'h1F, 5'h1D, 5'h1F, 5'h1F};
  wire logic [5:0] seen = {mrx, rxfe, pa, cal, pll, xtal};
  rmsi_link_if link ();
  rmsi_radio #(.XTAL_CYCLES(8), .CAL_CYCLES(4), .SETTLE_CYCLES(4)) u_rmsi_radio (
    .hclk(hclk), .hresetn(hresetn), .link(link), .ev_first(ev_first),
    .ev_second(ev_second), .fifo_flags(fifo_flags), .tx_done(tx_done),
    .low_power_regulator_on(lpr), .main_reg_on(main_on), .wut_on(wut), .lbd_on(lbd),
    .xtal_on(xtal), .xtal_buf_on(xbuf), .pll_on(pll), .vco_cal_on(cal), .pa_on(pa),
    .rx_front_on(rxfe), .modem_rx_on(mrx));
  rmsi_host u_rmsi_host (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .host_irq(host_irq), .link(link));
  rmsi_monitor u_rmsi_monitor (
    .hclk(hclk), .hresetn(hresetn), .reg_req(link.reg_req), .reg_we(link.reg_we),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .reg_ack(link.reg_ack), .irq_out_low(link.irq_out_low));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // first cycle each sequencer output is seen on, -1 until then
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++)
      if (seen[i] && t[i] < 0) t[i] <= cyc;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val
  task automatic check_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit
  task automatic hang;
    miscompares++;
    $display("ERROR wait expected done seen timeout");
    give_verdict();
  endtask : hang
  task automatic wait_rdy;
    int n;
    @(posedge hclk);
    for (n = 0; hready !== 1'b1 && n < 50; n++)
      @(posedge hclk);
    if (hready !== 1'b1) hang();
  endtask : wait_rdy
  // one bus transfer: address phase, then data phase, read data at its end
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb
  // radio access: command word, then poll until the link is free
  task automatic rad(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    ahb(1'b1, HOFF_CMD, {15'h0, w, d, 1'b0, a});
    ahb(1'b0, HOFF_STAT, 32'h0);
    for (n = 0; rd[STAT_BUSY_BIT] !== 1'b0 && n < 20; n++)
      ahb(1'b0, HOFF_STAT, 32'h0);
    if (rd[STAT_BUSY_BIT] !== 1'b0) hang();
  endtask : rad
  task automatic rrd(input logic [6:0] a, input logic [7:0] e, input string nm);
    rad(1'b0, a, 8'h00);
    check_val(nm, {24'h0, e}, rd & 32'hFF);
  endtask : rrd
  task automatic wait_cps(input logic [1:0] c);
    int n;
    rad(1'b0, ADR_DEV_STATUS, 8'h00);
    for (n = 0; rd[1:0] !== c && n < 300; n++)
      rad(1'b0, ADR_DEV_STATUS, 8'h00);
    if (rd[1:0] !== c) hang();
  endtask : wait_cps
  // pin is only looked at mid-cycle, once register updates have landed
  task automatic irq_is(input logic e);
    @(negedge hclk);
    check_bit("irq pin", e, ~link.irq_out_low);
    check_bit("host irq", e, host_irq);
    @(posedge hclk);
  endtask : irq_is
  task automatic pulse(input logic [7:0] f, input logic [7:0] s, input logic d);
    ev_first <= f;
    ev_second <= s;
    tx_done <= d;
    @(posedge hclk);
    ev_first <= 8'h00;
    ev_second <= 8'h00;
    tx_done <= 1'b0;
  endtask : pulse
  task automatic clr_t;
    for (int i = 0; i < 6; i++)
      t[i] <= -1;
  endtask : clr_t
  initial
  begin
    {hresetn, hwrite, tx_done, haddr, hwdata, htrans} = '0;
    {ev_first, ev_second, fifo_flags} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    clr_t();
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    irq_is(1'b1);
    check_bit("ready mode", 1'b1, xtal & main_on & lpr & xbuf & ~pll);
    rrd(ADR_IEN_FIRST, 8'h00, "enable one reset");
    rrd(ADR_IEN_SECOND, 8'h01, "enable two reset");
    rrd(ADR_OPMODE, 8'h01, "opmode reset");
    rrd(ADR_SEQ_CFG, 8'h00, "skip cal reset");
    rrd(ADR_IST_SECOND, 8'h01, "por flag");
    irq_is(1'b0);
    rrd(ADR_IST_SECOND, 8'h00, "por flag cleared");
    // read-only status ignores a write and mirrors fifo levels
    fifo_flags <= 5'h15;
    rad(1'b1, ADR_DEV_STATUS, 8'hFF);
    rrd(ADR_DEV_STATUS, 8'hA8, "device status");
    fifo_flags <= 5'h00;
    rrd(7'h7F, 8'h00, "unmapped radio read");
    ahb(1'b0, 32'h0000_0010, 32'h0);
    check_val("unmapped bus read", 32'h0, rd);
    check_bit("bus response", 1'b0, hresp);
    // buffer override in ready mode; host returns it to zero before leaving ready
    rad(1'b1, ADR_XTAL_CTL, 8'h02);
    check_bit("buffer off", 1'b0, xbuf);
    rrd(ADR_XTAL_CTL, 8'h02, "crystal control");
    rad(1'b1, ADR_XTAL_CTL, 8'h00);
    check_bit("buffer on", 1'b1, xbuf);
    for (int i = 0; i < 5; i++)
    begin
      rad(1'b1, ADR_OPMODE, mode_v[i]);
      check_val("mode blocks", {27'h0, mode_e[i]},
        {27'h0, {main_on, xtal, pll, wut, lbd} & mode_m[i]});
    end
    // transmit from standby runs the whole chain
    rad(1'b1, ADR_OPMODE, 8'h00);
    clr_t();
    rad(1'b1, ADR_OPMODE, 8'h08);
    wait_cps(CPS_TX);
    check_bit("tx order", 1'b1, t[0] >= 0 && t[1] - t[0] >= 8 && t[2] >= t[1] &&
      t[3] - t[2] >= 8);
    pulse(8'h00, 8'h00, 1'b1);
    wait_cps(CPS_IDLE);
    rrd(ADR_OPMODE, 8'h00, "txon cleared");
    // receive from ready with calibration skipped
    rad(1'b1, ADR_SEQ_CFG, 8'h01);
    rad(1'b1, ADR_OPMODE, 8'h01);
    clr_t();
    rad(1'b1, ADR_OPMODE, 8'h05);
    wait_cps(CPS_RX);
    check_bit("rx order", 1'b1, t[2] < 0 && t[1] >= 0 && t[4] >= t[1] && t[5] > t[4]);
    rad(1'b1, ADR_OPMODE, 8'h00);
    wait_cps(CPS_IDLE);
    check_val("standby after rx", 32'h0, {29'h0, pll, rxfe, mrx});
    // transmit from tune: pll already locked, no calibration
    rad(1'b1, ADR_SEQ_CFG, 8'h00);
    rad(1'b1, ADR_OPMODE, 8'h02);
    clr_t();
    rad(1'b1, ADR_OPMODE, 8'h0A);
    wait_cps(CPS_TX);
    check_bit("tune skips cal", 1'b1, t[2] < 0 && t[3] >= 0);
    pulse(8'h00, 8'h00, 1'b1);
    wait_cps(CPS_IDLE);
    // flags are handled in sleep, opmode 40 with only the wake-up timer and the low-power regulator on
    rad(1'b1, ADR_OPMODE, 8'h40);
    check_bit("sleep main off", 1'b0, main_on);
    // one enabled and one disabled flag in the first register
    rad(1'b1, ADR_IEN_FIRST, 8'h04);
    pulse(8'h24, 8'h00, 1'b0);
    irq_is(1'b1);
    ahb(1'b0, HOFF_STAT, 32'h0);
    check_bit("stat irq", 1'b1, rd[STAT_IRQ_BIT]);
    rrd(ADR_IST_FIRST, 8'h24, "status one");
    irq_is(1'b0);
    rrd(ADR_IST_FIRST, 8'h20, "disabled flag kept");
    pulse(8'h20, 8'h00, 1'b0);
    irq_is(1'b0);
    // second register: a pending flag released by clearing its enable
    rad(1'b1, ADR_IEN_SECOND, 8'h08);
    pulse(8'h00, 8'h08, 1'b0);
    irq_is(1'b1);
    rrd(ADR_IEN_SECOND, 8'h08, "enable two");
    rad(1'b1, ADR_IEN_SECOND, 8'h00);
    irq_is(1'b0);
    rrd(ADR_IST_SECOND, 8'h08, "disabled flag readable");
    give_verdict();
  end
endmodule : test_radio_mode_sequencer_irq

// ### src/rmsi_host.sv
// controller end: AHB-Lite slave that turns command writes into radio register accesses
// assumes one AHB master, single word transfers, and the radio end on the link
`timescale 1ns/1ps
module rmsi_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic host_irq,
  rmsi_link_if.host link
);
  import rmsi_pkg::*;

  typedef struct packed {
    logic dph_valid;
    logic dph_we;
    logic [31:0] dph_addr;
    logic busy;
    logic req;
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [31:0] hrdata;
  } rmsi_host_t;

  rmsi_host_t state_reg;
  rmsi_host_t state_next;
  logic aph;

  // address phase accepted on any NONSEQ/SEQ with the bus ready
  assign aph = hsel & hready & htrans[1];

  // command start, link handshake and read data
  always_comb
  begin
    state_next = state_reg;
    // data phase of a command write; ignored while an access is still busy
    if (state_reg.dph_valid && state_reg.dph_we && state_reg.dph_addr == HOFF_CMD
        && !state_reg.busy)
    begin
      state_next.busy = 1'b1;
      state_next.req = 1'b1;
      state_next.addr = hwdata[6:0];
      state_next.wdata = hwdata[CMD_WDATA_LSB +: 8];
      state_next.we = hwdata[CMD_WRITE_BIT];
    end
    // ack ends the access; read data captured with it
    if (state_reg.req && link.reg_ack)
    begin
      state_next.req = 1'b0;
      state_next.busy = 1'b0;
      if (!state_reg.we)
      begin
        state_next.rdata = link.reg_rdata;
      end
    end
    state_next.dph_valid = aph;
    state_next.dph_we = hwrite;
    state_next.dph_addr = haddr;
    // read data registered at the address phase, unmapped reads zero
    if (aph && !hwrite)
    begin
      case (haddr)
        HOFF_CMD: state_next.hrdata = {15'h0000, state_reg.we, state_reg.wdata,
                                       1'b0, state_reg.addr};
        HOFF_STAT: state_next.hrdata = {22'h00_0000, ~link.irq_out_low, state_reg.busy,
                                        state_reg.rdata};
        default: state_next.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // single register for all state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // zero wait states, always OKAY; the pin is looped back as a level interrupt
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.hrdata;
  assign host_irq = ~link.irq_out_low;
  assign link.reg_req = state_reg.req;
  assign link.reg_we = state_reg.we;
  assign link.reg_addr = state_reg.addr;
  assign link.reg_wdata = state_reg.wdata;
endmodule : rmsi_host

// ### src/rmsi_link_if.sv
// register link between the controller and the radio end, plus the interrupt pin
// assumes both ends run on the same clock; the bench ties the two modports together
`timescale 1ns/1ps
interface rmsi_link_if;
  logic reg_req;
  logic reg_we;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  logic irq_out_low;

  modport radio (
    input reg_req,
    input reg_we,
    input reg_addr,
    input reg_wdata,
    output reg_rdata,
    output reg_ack,
    output irq_out_low
  );
  modport host (
    output reg_req,
    output reg_we,
    output reg_addr,
    output reg_wdata,
    input reg_rdata,
    input reg_ack,
    input irq_out_low
  );
endinterface : rmsi_link_if

// ### src/rmsi_pkg.sv
// constants, register map, field positions and sequencer states for the radio mode block
// assumes a single 100 MHz clock shared by the controller and the radio end
package rmsi_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TMR_W = 20;
  // radio register offsets
  localparam logic [6:0] ADR_DEV_STATUS = 7'h02;
  localparam logic [6:0] ADR_IST_FIRST = 7'h03;
  localparam logic [6:0] ADR_IST_SECOND = 7'h04;
  localparam logic [6:0] ADR_IEN_FIRST = 7'h05;
  localparam logic [6:0] ADR_IEN_SECOND = 7'h06;
  localparam logic [6:0] ADR_OPMODE = 7'h07;
  localparam logic [6:0] ADR_SEQ_CFG = 7'h08;
  localparam logic [6:0] ADR_XTAL_CTL = 7'h62;
  // operating mode, crystal control and sequencer config bit positions
  localparam int unsigned OPM_XTON = 0;
  localparam int unsigned OPM_PLLON = 1;
  localparam int unsigned OPM_RXON = 2;
  localparam int unsigned OPM_TXON = 3;
  localparam int unsigned OPM_ENLBD = 5;
  localparam int unsigned OPM_ENWT = 6;
  localparam int unsigned XCTL_BUFOVR = 1;
  localparam int unsigned SEQ_SKIPVCO = 0;
  // values after reset
  localparam logic [7:0] OPMODE_RST = 8'h01;
  localparam logic [7:0] XTAL_CTL_RST = 8'h00;
  localparam logic [7:0] SEQ_CFG_RST = 8'h00;
  localparam logic [7:0] IEN_FIRST_RST = 8'h00;
  localparam logic [7:0] IEN_SECOND_RST = 8'h01;
  localparam logic [7:0] IST_FIRST_RST = 8'h00;
  localparam logic [7:0] IST_SECOND_RST = 8'h01;
  // chip power state codes
  localparam logic [1:0] CPS_IDLE = 2'h0;
  localparam logic [1:0] CPS_RX = 2'h1;
  localparam logic [1:0] CPS_TX = 2'h2;
  // sequencer step times and derived cycle counts (least times, rounded up)
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_XTAL_NS = 600000;
  localparam int unsigned T_CAL_NS = 100000;
  localparam int unsigned T_SETTLE_NS = 100000;
  localparam int unsigned T_PA_NS = 5000;
  localparam int unsigned XTAL_CYC = (T_XTAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CAL_CYC = (T_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PA_CYC = (T_PA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // controller register offsets and fields
  localparam logic [31:0] HOFF_CMD = 32'h0000_0000;
  localparam logic [31:0] HOFF_STAT = 32'h0000_0004;
  localparam int unsigned CMD_WDATA_LSB = 8;
  localparam int unsigned CMD_WRITE_BIT = 16;
  localparam int unsigned STAT_BUSY_BIT = 8;
  localparam int unsigned STAT_IRQ_BIT = 9;

  typedef enum logic [3:0] {
    SQ_IDLE, SQ_REG, SQ_XTAL, SQ_PLL, SQ_CAL, SQ_SETTLE, SQ_PA, SQ_TX, SQ_RXFE, SQ_RX
  } rmsi_seq_t;
endpackage : rmsi_pkg

// ### src/rmsi_radio.sv
// radio end: mode registers, power-up sequencer, status and read-clear interrupts
// assumes the controller holds reg_req until it samples reg_ack
`timescale 1ns/1ps
module rmsi_radio #(
  parameter int unsigned XTAL_CYCLES = rmsi_pkg::XTAL_CYC,
  parameter int unsigned CAL_CYCLES = rmsi_pkg::CAL_CYC,
  parameter int unsigned SETTLE_CYCLES = rmsi_pkg::SETTLE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  rmsi_link_if.radio link,
  input wire logic [7:0] ev_first,
  input wire logic [7:0] ev_second,
  input wire logic [4:0] fifo_flags,
  input wire logic tx_done,
  output logic low_power_regulator_on,
  output logic main_reg_on,
  output logic wut_on,
  output logic lbd_on,
  output logic xtal_on,
  output logic xtal_buf_on,
  output logic pll_on,
  output logic vco_cal_on,
  output logic pa_on,
  output logic rx_front_on,
  output logic modem_rx_on
);
  import rmsi_pkg::*;

  typedef struct packed {
    logic [7:0] opmode;
    logic [7:0] xtal_ctl;
    logic [7:0] seq_cfg;
    logic [7:0] ien_first;
    logic [7:0] ien_second;
    logic [7:0] ist_first;
    logic [7:0] ist_second;
    logic [7:0] rdata;
    logic ack;
    rmsi_seq_t seq;
    logic [TMR_W-1:0] tmr;
  } rmsi_radio_t;

  rmsi_radio_t state_reg;
  rmsi_radio_t state_next;
  logic take;
  logic rd_take;
  logic wr_take;
  logic want_tx;
  logic want_rx;
  logic idle_xtal;
  logic [1:0] cps;

  // power state field for the status register
  function automatic logic [1:0] rmsi_cps(input rmsi_seq_t s);
    case (s)
      SQ_TX: rmsi_cps = CPS_TX;
      SQ_RX: rmsi_cps = CPS_RX;
      default: rmsi_cps = CPS_IDLE;
    endcase
  endfunction : rmsi_cps

  // true once the crystal is running because of the sequencer itself
  function automatic logic rmsi_xtal_by_seq(input rmsi_seq_t s);
    rmsi_xtal_by_seq = (s != SQ_IDLE) && (s != SQ_REG) && (s != SQ_XTAL);
  endfunction : rmsi_xtal_by_seq

  // cycle count to timer width; counts are known to fit
  function automatic logic [TMR_W-1:0] rmsi_cnt(input int unsigned c);
    rmsi_cnt = TMR_W'(c);
  endfunction : rmsi_cnt

  // request decode: a request is taken once, the cycle ack is low
  assign take = link.reg_req & ~state_reg.ack;
  assign rd_take = take & ~link.reg_we;
  assign wr_take = take & link.reg_we;
  assign want_tx = state_reg.opmode[OPM_TXON];
  assign want_rx = state_reg.opmode[OPM_RXON];
  assign idle_xtal = state_reg.opmode[OPM_XTON] | state_reg.opmode[OPM_PLLON];
  assign cps = rmsi_cps(state_reg.seq);

  // next-state logic for registers, interrupts and sequencer
  always_comb
  begin
    state_next = state_reg;
    state_next.ack = take;
    // read mux; reserved bit 2 of status reads zero
    if (rd_take)
    begin
      case (link.reg_addr)
        ADR_DEV_STATUS: state_next.rdata = {fifo_flags, 1'b0, cps};
        ADR_IST_FIRST: state_next.rdata = state_reg.ist_first;
        ADR_IST_SECOND: state_next.rdata = state_reg.ist_second;
        ADR_IEN_FIRST: state_next.rdata = state_reg.ien_first;
        ADR_IEN_SECOND: state_next.rdata = state_reg.ien_second;
        ADR_OPMODE: state_next.rdata = state_reg.opmode;
        ADR_SEQ_CFG: state_next.rdata = state_reg.seq_cfg;
        ADR_XTAL_CTL: state_next.rdata = state_reg.xtal_ctl;
        default: state_next.rdata = 8'h00;
      endcase
    end
    // read clears enabled flags; a new event in the same cycle still sets
    if (rd_take && link.reg_addr == ADR_IST_FIRST)
    begin
      state_next.ist_first = state_reg.ist_first & ~state_reg.ien_first;
    end
    if (rd_take && link.reg_addr == ADR_IST_SECOND)
    begin
      state_next.ist_second = state_reg.ist_second & ~state_reg.ien_second;
    end
    // flags latch whether enabled or not
    state_next.ist_first = state_next.ist_first | ev_first;
    state_next.ist_second = state_next.ist_second | ev_second;
    // register writes; zero to opmode gives standby
    if (wr_take)
    begin
      case (link.reg_addr)
        ADR_OPMODE: state_next.opmode = link.reg_wdata;
        ADR_SEQ_CFG: state_next.seq_cfg = link.reg_wdata;
        ADR_XTAL_CTL: state_next.xtal_ctl = link.reg_wdata;
        ADR_IEN_FIRST: state_next.ien_first = link.reg_wdata;
        ADR_IEN_SECOND: state_next.ien_second = link.reg_wdata;
        default: state_next.seq = state_reg.seq;
      endcase
    end
    // a finished packet drops txon so the device falls back to idle
    if (state_reg.seq == SQ_TX && tx_done && !wr_take)
    begin
      state_next.opmode[OPM_TXON] = 1'b0;
    end
    // timer runs down in the timed steps
    if (state_reg.tmr != '0)
    begin
      state_next.tmr = state_reg.tmr - 1'b1;
    end
    // power-up sequencer
    case (state_reg.seq)
      SQ_IDLE:
      begin
        if (want_tx || want_rx)
        begin
          state_next.seq = SQ_REG;
        end
      end
      SQ_REG:
      begin
        if (!state_reg.opmode[OPM_PLLON] && idle_xtal)
        begin
          state_next.seq = SQ_PLL;
        end
        else if (state_reg.opmode[OPM_PLLON])
        begin
          state_next.seq = want_tx ? SQ_PA : SQ_RXFE;
          state_next.tmr = rmsi_cnt(PA_CYC);
        end
        else
        begin
          state_next.seq = SQ_XTAL;
          state_next.tmr = rmsi_cnt(XTAL_CYCLES);
        end
      end
      SQ_XTAL:
      begin
        if (state_reg.tmr == '0)
        begin
          state_next.seq = SQ_PLL;
        end
      end
      SQ_PLL:
      begin
        // calibration reruns each time the pll comes on unless seq_cfg bit SEQ_SKIPVCO is set
        if (state_reg.seq_cfg[SEQ_SKIPVCO])
        begin
          state_next.seq = SQ_SETTLE;
          state_next.tmr = rmsi_cnt(SETTLE_CYCLES);
        end
        else
        begin
          state_next.seq = SQ_CAL;
          state_next.tmr = rmsi_cnt(CAL_CYCLES);
        end
      end
      SQ_CAL:
      begin
        if (state_reg.tmr == '0)
        begin
          state_next.seq = SQ_SETTLE;
          state_next.tmr = rmsi_cnt(SETTLE_CYCLES);
        end
      end
      SQ_SETTLE:
      begin
        if (state_reg.tmr == '0)
        begin
          state_next.seq = want_tx ? SQ_PA : SQ_RXFE;
          state_next.tmr = rmsi_cnt(PA_CYC);
        end
      end
      SQ_PA:
      begin
        if (state_reg.tmr == '0)
        begin
          state_next.seq = SQ_TX;
        end
      end
      SQ_TX:
      begin
        if (!state_next.opmode[OPM_TXON])
        begin
          state_next.seq = SQ_IDLE;
        end
      end
      SQ_RXFE: state_next.seq = SQ_RX;
      SQ_RX:
      begin
        if (!state_next.opmode[OPM_RXON])
        begin
          state_next.seq = SQ_IDLE;
        end
      end
      default: state_next.seq = SQ_IDLE;
    endcase
    // clearing both request bits mid-sequence aborts back to idle
    if (state_reg.seq != SQ_IDLE && !state_next.opmode[OPM_TXON]
        && !state_next.opmode[OPM_RXON])
    begin
      state_next.seq = SQ_IDLE;
      state_next.tmr = '0;
    end
  end

  // single register for all state; reset leaves ready mode and a pending por flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg.opmode <= OPMODE_RST;
      state_reg.xtal_ctl <= XTAL_CTL_RST;
      state_reg.seq_cfg <= SEQ_CFG_RST;
      state_reg.ien_first <= IEN_FIRST_RST;
      state_reg.ien_second <= IEN_SECOND_RST;
      state_reg.ist_first <= IST_FIRST_RST;
      state_reg.ist_second <= IST_SECOND_RST;
      state_reg.rdata <= 8'h00;
      state_reg.ack <= 1'b0;
      state_reg.seq <= SQ_IDLE;
      state_reg.tmr <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // link outputs; pin is low while any enabled flag is pending
  assign link.reg_rdata = state_reg.rdata;
  assign link.reg_ack = state_reg.ack;
  assign link.irq_out_low = ~|((state_reg.ist_first & state_reg.ien_first)
                             | (state_reg.ist_second & state_reg.ien_second));

  // block enables; the main regulator is off only in standby and sleep
  assign low_power_regulator_on = 1'b1;
  assign main_reg_on = (state_reg.seq != SQ_IDLE) | idle_xtal
                       | state_reg.opmode[OPM_ENLBD];
  assign wut_on = state_reg.opmode[OPM_ENWT];
  assign lbd_on = state_reg.opmode[OPM_ENLBD];
  assign xtal_on = idle_xtal | (state_reg.seq == SQ_XTAL)
                   | rmsi_xtal_by_seq(state_reg.seq);
  // buffer override saves current in ready mode at the cost of the crystal buffer
  assign xtal_buf_on = xtal_on & ~state_reg.xtal_ctl[XCTL_BUFOVR];
  assign pll_on = state_reg.opmode[OPM_PLLON]
                  | (rmsi_xtal_by_seq(state_reg.seq) && state_reg.seq != SQ_RXFE
                  && state_reg.seq != SQ_RX) | (state_reg.seq == SQ_RXFE)
                  | (state_reg.seq == SQ_RX);
  assign vco_cal_on = (state_reg.seq == SQ_CAL);
  assign pa_on = (state_reg.seq == SQ_PA) | (state_reg.seq == SQ_TX);
  assign rx_front_on = (state_reg.seq == SQ_RXFE) | (state_reg.seq == SQ_RX);
  // the modem itself (gain, sync, packet) sits outside and keys on this enable
  assign modem_rx_on = (state_reg.seq == SQ_RX);
endmodule : rmsi_radio
